// ### sid_pkg.sv
// Constants, types and configuration layout of the scan indicator driver
package sid_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_MS     = 1000000;
  localparam int NS_PER_S      = 1000000000;
  localparam int MS_CYCLES     = (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_HZ        = NS_PER_S / CLK_PERIOD_NS;
  localparam int CNT_W         = 32;
  localparam int FREQ_W        = 14;
  localparam int MS_W          = 10;

  localparam logic [13:0] FREQ_DEF     = 14'h0bb8;
  localparam logic [13:0] FREQ_PARTIAL = 14'h1388;
  localparam logic [13:0] FREQ_HIGH    = 14'h0fa0;
  localparam logic [13:0] FREQ_LOW     = 14'h07d0;
  localparam logic [13:0] FREQ_ERROR   = 14'h03e8;
  localparam logic [13:0] DIG_K3       = 14'h03e8;
  localparam logic [13:0] DIG_K2       = 14'h0064;
  localparam logic [13:0] DIG_K1       = 14'h000a;
  localparam logic [3:0]  DIGIT_MAX    = 4'h9;

  localparam logic [9:0] BEEP_MS_50   = 10'h032;
  localparam logic [9:0] BEEP_MS_75   = 10'h04b;
  localparam logic [9:0] BEEP_MS_100  = 10'h064;
  localparam logic [9:0] BEEP_MS_200  = 10'h0c8;
  localparam logic [9:0] BEEP_MS_400  = 10'h190;
  localparam logic [9:0] PARTIAL_MS   = 10'h00a;
  localparam logic [9:0] STARTUP_MS   = 10'h064;
  localparam logic [9:0] ERROR_MS     = 10'h0c8;
  localparam logic [9:0] LAMP_MS_60   = 10'h03c;
  localparam logic [9:0] LAMP_MS_100  = 10'h064;
  localparam logic [9:0] LAMP_MS_200  = 10'h0c8;
  localparam logic [9:0] LAMP_MS_400  = 10'h190;
  localparam logic [9:0] LAMP_MS_800  = 10'h320;

  localparam logic       IDLE_HIGH_DEF  = 1'b1;
  localparam logic       LAMP_OFF_LEVEL = 1'b1;
  localparam logic [1:0] BOOT_CAPTURE   = 2'h0;
  localparam logic [1:0] BOOT_BEEP      = 2'h1;
  localparam logic [1:0] BOOT_DONE      = 2'h2;

  typedef enum logic [1:0] {
    SID_LOUD_MAX    = 2'h0,
    SID_LOUD_LOUD   = 2'h1,
    SID_LOUD_NORMAL = 2'h2,
    SID_LOUD_MIN    = 2'h3
  } sid_loud_type;

  typedef enum logic [1:0] {
    SID_TONE_MEDIUM = 2'h0,
    SID_TONE_DOWN   = 2'h1,
    SID_TONE_UP     = 2'h2
  } sid_tone_type;

  typedef enum logic [1:0] {
    SID_IDLE   = 2'b00,
    SID_FIRST  = 2'b01,
    SID_SECOND = 2'b11
  } sid_beep_state_type;

  typedef struct packed {
    sid_loud_type loud;
    logic         ok_en;
    logic [9:0]   beep_ms;
    sid_tone_type tone;
    logic [13:0]  freq;
    logic         timeout_en;
    logic         partial_en;
    logic         lamp_en;
    logic [9:0]   lamp_ms;
    logic         lamp_inv;
    logic         after_send;
  } sid_cfg_type;

  localparam sid_cfg_type CFG_RESET = '{
    loud: SID_LOUD_MAX, ok_en: 1'b1, beep_ms: BEEP_MS_50, tone: SID_TONE_MEDIUM,
    freq: FREQ_DEF, timeout_en: 1'b0, partial_en: 1'b1, lamp_en: 1'b1,
    lamp_ms: LAMP_MS_200, lamp_inv: 1'b0, after_send: 1'b0};
endpackage

// ### sid_tone.sv
// Phase-accumulator tone generator with loudness-dependent pulse width
`timescale 1ns/100ps
module sid_tone #(
  parameter int CLK_HZ = sid_pkg::CLK_HZ
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                en,
  input  wire logic [13:0]         freq,
  input  wire sid_pkg::sid_loud_type loud,
  input  wire logic                idle_high,
  output logic                     drive_out
);
  localparam int PH_W = $clog2(CLK_HZ) + 1;
  localparam logic [PH_W-1:0] PH_TOP = PH_W'(CLK_HZ);

  if (CLK_HZ < 20000) begin : g_bad_clk
    $error("Clock too slow for the tone range");
  end

  logic [PH_W-1:0] phase_reg;
  logic [PH_W-1:0] phase_next;
  logic [PH_W-1:0] duty_lim;

  // Adding freq each cycle and wrapping at CLK_HZ divides the clock to
  // the tone exactly on average, without a runtime divider
  always_comb begin
    phase_next = phase_reg + PH_W'(freq);
    if (phase_next >= PH_TOP) begin
      phase_next = phase_next - PH_TOP;
    end
  end

  // Quieter settings shorten the active part of each period
  assign duty_lim = PH_TOP >> (PH_W'(loud) + 1'b1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= '0;
    end else if (!en) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_out <= sid_pkg::IDLE_HIGH_DEF;
    end else if (en) begin
      drive_out <= (phase_reg < duty_lim) ^ idle_high;
    end else begin
      drive_out <= idle_high;
    end
  end
endmodule

// ### sid_indicator.sv
// Buzzer and good-read lamp driver of the scan engine
// Behaviour
// - Buzzer output is a PWM tone waveform.
// - Four loudness levels, same for all beeps.
// - Good-read beep on each read when enabled.
// - Good-read beep length 50 to 400 ms.
// - Medium tone or two-step down/up tones.
// - Four-digit decimal tone frequency, 1 to 9999.
// - Optional single power-on beep, default off.
// - Optional error beep on read timeout.
// - Intermediate beep until final decode qualifies.
// - Intermediate beep is 5000 Hz, 10 ms.
// - Intermediate beep muted when good-read beep off.
// - Configurable buzzer idle level, default high.
// - Lamp on 60 to 800 ms or disabled.
// - Inverted mode complements the lamp output.
// - Indicate before or after data transmission.
`timescale 1ns/100ps
module sid_indicator #(
  parameter int MS_CYC = sid_pkg::MS_CYCLES,
  parameter int CLK_HZ = sid_pkg::CLK_HZ
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        loudness_max_cmd,
  input  wire logic        loudness_loud_cmd,
  input  wire logic        loudness_normal_cmd,
  input  wire logic        loudness_min_cmd,
  input  wire logic        ok_beep_on_cmd,
  input  wire logic        ok_beep_off_cmd,
  input  wire logic        beep_len_50_cmd,
  input  wire logic        beep_len_75_cmd,
  input  wire logic        beep_len_100_cmd,
  input  wire logic        beep_len_200_cmd,
  input  wire logic        beep_len_400_cmd,
  input  wire logic        tone_medium_cmd,
  input  wire logic        tone_step_down_cmd,
  input  wire logic        tone_step_up_cmd,
  input  wire logic        tone_freq_set_cmd,
  input  wire logic [15:0] tone_freq_digits,
  input  wire logic        power_beep_off_cmd,
  input  wire logic        power_beep_on_cmd,
  input  wire logic        timeout_beep_off_cmd,
  input  wire logic        timeout_beep_on_cmd,
  input  wire logic        partial_beep_cmd,
  input  wire logic        partial_beep_val,
  input  wire logic        beep_idle_low_cmd,
  input  wire logic        beep_idle_high_cmd,
  input  wire logic        lamp_off_cmd,
  input  wire logic        lamp_len_60_cmd,
  input  wire logic        lamp_len_100_cmd,
  input  wire logic        lamp_len_200_cmd,
  input  wire logic        lamp_len_400_cmd,
  input  wire logic        lamp_len_800_cmd,
  input  wire logic        lamp_polarity_normal_cmd,
  input  wire logic        lamp_polarity_invert_cmd,
  input  wire logic        save_settings_cmd,
  input  wire logic        indicate_before_send_cmd,
  input  wire logic        indicate_after_send_cmd,
  input  wire logic        stored_power_beep,
  input  wire logic        stored_idle_high,
  input  wire logic        decode_ok,
  input  wire logic        decode_partial,
  input  wire logic        read_timeout,
  input  wire logic        data_sent,
  output logic             tone_drive_out,
  output logic             read_ok_lamp_out
);
  if (MS_CYC < 2) begin : g_bad_ms
    $error("MS_CYC must be at least 2");
  end

  function automatic logic [31:0] ms_cyc(input logic [9:0] ms);
    return 32'(32'(ms) * 32'(MS_CYC));
  endfunction

  sid_pkg::sid_cfg_type        cfg_reg;
  sid_pkg::sid_beep_state_type beep_state_reg;
  logic        power_pend_reg;
  logic        power_act_reg;
  logic        idle_pend_reg;
  logic        idle_act_reg;
  logic [1:0]  boot_reg;
  logic        send_wait_reg;
  logic [31:0] beep_left_reg;
  logic [31:0] beep_half_reg;
  logic [13:0] beep_freq_reg;
  logic [13:0] beep_freq2_reg;
  logic        beep_two_reg;
  logic [31:0] lamp_left_reg;
  logic        lamp_out_reg;
  logic [13:0] dig_val;
  logic        dig_ok;
  logic        ok_fire;
  logic        ok_go;
  logic        part_go;
  logic        tmo_go;
  logic        boot_go;
  logic        lamp_go;
  logic        start;
  logic [9:0]  ld_ms;
  logic [13:0] ld_f1;
  logic [13:0] ld_f2;
  logic        ld_two;

  assign dig_val = 14'(tone_freq_digits[15:12] * sid_pkg::DIG_K3)
                 + 14'(tone_freq_digits[11:8] * sid_pkg::DIG_K2)
                 + 14'(tone_freq_digits[7:4] * sid_pkg::DIG_K1)
                 + 14'(tone_freq_digits[3:0]);
  // Any digit above nine or a zero total leaves the frequency unchanged
  assign dig_ok = (tone_freq_digits[15:12] <= sid_pkg::DIGIT_MAX)
               && (tone_freq_digits[11:8] <= sid_pkg::DIGIT_MAX)
               && (tone_freq_digits[7:4] <= sid_pkg::DIGIT_MAX)
               && (tone_freq_digits[3:0] <= sid_pkg::DIGIT_MAX)
               && (dig_val != '0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= sid_pkg::CFG_RESET;
    end else begin
      if (loudness_max_cmd) cfg_reg.loud <= sid_pkg::SID_LOUD_MAX;
      if (loudness_loud_cmd) cfg_reg.loud <= sid_pkg::SID_LOUD_LOUD;
      if (loudness_normal_cmd) cfg_reg.loud <= sid_pkg::SID_LOUD_NORMAL;
      if (loudness_min_cmd) cfg_reg.loud <= sid_pkg::SID_LOUD_MIN;
      if (ok_beep_on_cmd) cfg_reg.ok_en <= 1'b1;
      if (ok_beep_off_cmd) cfg_reg.ok_en <= 1'b0;
      if (beep_len_50_cmd) cfg_reg.beep_ms <= sid_pkg::BEEP_MS_50;
      if (beep_len_75_cmd) cfg_reg.beep_ms <= sid_pkg::BEEP_MS_75;
      if (beep_len_100_cmd) cfg_reg.beep_ms <= sid_pkg::BEEP_MS_100;
      if (beep_len_200_cmd) cfg_reg.beep_ms <= sid_pkg::BEEP_MS_200;
      if (beep_len_400_cmd) cfg_reg.beep_ms <= sid_pkg::BEEP_MS_400;
      if (tone_medium_cmd) cfg_reg.tone <= sid_pkg::SID_TONE_MEDIUM;
      if (tone_step_down_cmd) cfg_reg.tone <= sid_pkg::SID_TONE_DOWN;
      if (tone_step_up_cmd) cfg_reg.tone <= sid_pkg::SID_TONE_UP;
      if (tone_freq_set_cmd && dig_ok) cfg_reg.freq <= dig_val;
      if (timeout_beep_on_cmd) cfg_reg.timeout_en <= 1'b1;
      if (timeout_beep_off_cmd) cfg_reg.timeout_en <= 1'b0;
      if (partial_beep_cmd) cfg_reg.partial_en <= partial_beep_val;
      if (lamp_off_cmd) cfg_reg.lamp_en <= 1'b0;
      if (lamp_len_60_cmd || lamp_len_100_cmd || lamp_len_200_cmd
          || lamp_len_400_cmd || lamp_len_800_cmd) cfg_reg.lamp_en <= 1'b1;
      if (lamp_len_60_cmd) cfg_reg.lamp_ms <= sid_pkg::LAMP_MS_60;
      if (lamp_len_100_cmd) cfg_reg.lamp_ms <= sid_pkg::LAMP_MS_100;
      if (lamp_len_200_cmd) cfg_reg.lamp_ms <= sid_pkg::LAMP_MS_200;
      if (lamp_len_400_cmd) cfg_reg.lamp_ms <= sid_pkg::LAMP_MS_400;
      if (lamp_len_800_cmd) cfg_reg.lamp_ms <= sid_pkg::LAMP_MS_800;
      if (lamp_polarity_normal_cmd) cfg_reg.lamp_inv <= 1'b0;
      if (lamp_polarity_invert_cmd) cfg_reg.lamp_inv <= 1'b1;
      if (indicate_before_send_cmd) cfg_reg.after_send <= 1'b0;
      if (indicate_after_send_cmd) cfg_reg.after_send <= 1'b1;
    end
  end

  // Startup and idle settings wait for a save; the stored copy is
  // loaded once, one edge after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_pend_reg <= 1'b0;
      power_act_reg  <= 1'b0;
      idle_pend_reg  <= sid_pkg::IDLE_HIGH_DEF;
      idle_act_reg   <= sid_pkg::IDLE_HIGH_DEF;
    end else if (boot_reg == sid_pkg::BOOT_CAPTURE) begin
      power_pend_reg <= stored_power_beep;
      power_act_reg  <= stored_power_beep;
      idle_pend_reg  <= stored_idle_high;
      idle_act_reg   <= stored_idle_high;
    end else begin
      if (power_beep_on_cmd) power_pend_reg <= 1'b1;
      if (power_beep_off_cmd) power_pend_reg <= 1'b0;
      if (beep_idle_high_cmd) idle_pend_reg <= 1'b1;
      if (beep_idle_low_cmd) idle_pend_reg <= 1'b0;
      if (save_settings_cmd) begin
        power_act_reg <= power_pend_reg;
        idle_act_reg  <= idle_pend_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_reg <= sid_pkg::BOOT_CAPTURE;
    end else if (boot_reg != sid_pkg::BOOT_DONE) begin
      boot_reg <= boot_reg + 2'h1;
    end
  end

  // A send that coincides with a new decode keeps the wait armed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      send_wait_reg <= 1'b0;
    end else if (decode_ok && cfg_reg.after_send) begin
      send_wait_reg <= 1'b1;
    end else if (data_sent) begin
      send_wait_reg <= 1'b0;
    end
  end

  assign ok_fire = cfg_reg.after_send ? (send_wait_reg && data_sent)
                                      : decode_ok;
  assign ok_go   = ok_fire && cfg_reg.ok_en;
  assign part_go = decode_partial && cfg_reg.partial_en && cfg_reg.ok_en;
  assign tmo_go  = read_timeout && cfg_reg.timeout_en;
  assign boot_go = (boot_reg == sid_pkg::BOOT_BEEP) && power_act_reg;
  assign lamp_go = ok_fire && cfg_reg.lamp_en;

  // Good read outranks intermediate, timeout and startup beeps
  always_comb begin
    start  = 1'b1;
    ld_ms  = cfg_reg.beep_ms;
    ld_f1  = cfg_reg.freq;
    ld_f2  = cfg_reg.freq;
    ld_two = 1'b0;
    if (ok_go) begin
      unique case (cfg_reg.tone)
        sid_pkg::SID_TONE_DOWN: begin
          ld_f1  = sid_pkg::FREQ_HIGH;
          ld_f2  = sid_pkg::FREQ_LOW;
          ld_two = 1'b1;
        end
        sid_pkg::SID_TONE_UP: begin
          ld_f1  = sid_pkg::FREQ_LOW;
          ld_f2  = sid_pkg::FREQ_HIGH;
          ld_two = 1'b1;
        end
        default: begin
          ld_two = 1'b0;
        end
      endcase
    end else if (part_go) begin
      ld_ms = sid_pkg::PARTIAL_MS;
      ld_f1 = sid_pkg::FREQ_PARTIAL;
    end else if (tmo_go) begin
      ld_ms = sid_pkg::ERROR_MS;
      ld_f1 = sid_pkg::FREQ_ERROR;
    end else if (boot_go) begin
      ld_ms = sid_pkg::STARTUP_MS;
    end else begin
      start = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      beep_state_reg <= sid_pkg::SID_IDLE;
      beep_left_reg  <= '0;
      beep_half_reg  <= '0;
      beep_freq_reg  <= sid_pkg::FREQ_DEF;
      beep_freq2_reg <= sid_pkg::FREQ_DEF;
      beep_two_reg   <= 1'b0;
    end else if (start) begin
      beep_state_reg <= sid_pkg::SID_FIRST;
      beep_left_reg  <= ms_cyc(ld_ms);
      beep_half_reg  <= ms_cyc(ld_ms) >> 1;
      beep_freq_reg  <= ld_f1;
      beep_freq2_reg <= ld_f2;
      beep_two_reg   <= ld_two;
    end else begin
      unique case (beep_state_reg)
        sid_pkg::SID_IDLE: begin
          beep_left_reg <= '0;
        end
        sid_pkg::SID_FIRST: begin
          beep_left_reg <= beep_left_reg - 32'h1;
          if (beep_left_reg <= 32'h1) begin
            beep_state_reg <= sid_pkg::SID_IDLE;
          end else if (beep_two_reg && beep_left_reg == beep_half_reg) begin
            beep_state_reg <= sid_pkg::SID_SECOND;
          end
        end
        sid_pkg::SID_SECOND: begin
          beep_left_reg <= beep_left_reg - 32'h1;
          if (beep_left_reg <= 32'h1) begin
            beep_state_reg <= sid_pkg::SID_IDLE;
          end
        end
        default: begin
          beep_state_reg <= sid_pkg::SID_IDLE;
        end
      endcase
    end
  end

  sid_tone #(
    .CLK_HZ(CLK_HZ)
  ) u_tone (
    .clk      (clk),
    .rstn     (rstn),
    .en       (beep_state_reg != sid_pkg::SID_IDLE),
    .freq     ((beep_state_reg == sid_pkg::SID_SECOND) ? beep_freq2_reg : beep_freq_reg),
    .loud     (cfg_reg.loud),
    .idle_high(idle_act_reg),
    .drive_out(tone_drive_out)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lamp_left_reg <= '0;
    end else if (lamp_go) begin
      lamp_left_reg <= ms_cyc(cfg_reg.lamp_ms);
    end else if (lamp_left_reg != '0) begin
      lamp_left_reg <= lamp_left_reg - 32'h1;
    end
  end

  // The lamp pin is active low in normal mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lamp_out_reg <= sid_pkg::LAMP_OFF_LEVEL;
    end else begin
      lamp_out_reg <= ~((lamp_left_reg != '0) ^ cfg_reg.lamp_inv);
    end
  end
  assign read_ok_lamp_out = lamp_out_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ok_start;
    ok_go && cfg_reg.tone == sid_pkg::SID_TONE_MEDIUM;
  endsequence
  sequence s_part_start;
    part_go && !ok_go;
  endsequence
  sequence s_half_reached;
    beep_state_reg == sid_pkg::SID_FIRST && beep_two_reg
      && beep_left_reg == beep_half_reg && beep_left_reg > 32'h1 && !start;
  endsequence

  ok_beep_len_a: assert property (s_ok_start |=>
    beep_state_reg == sid_pkg::SID_FIRST
    && beep_left_reg == ms_cyc($past(cfg_reg.beep_ms))
    && beep_freq_reg == $past(cfg_reg.freq))
    else $error("good-read beep not loaded");
  partial_tone_a: assert property (s_part_start |=>
    beep_freq_reg == sid_pkg::FREQ_PARTIAL
    && beep_left_reg == ms_cyc(sid_pkg::PARTIAL_MS))
    else $error("intermediate beep wrong");
  partial_mute_a: assert property (decode_partial && !cfg_reg.ok_en
    && beep_state_reg == sid_pkg::SID_IDLE && !tmo_go && !boot_go
    |=> beep_state_reg == sid_pkg::SID_IDLE)
    else $error("intermediate beep while good-read off");
  step_half_a: assert property (s_half_reached |=>
    beep_state_reg == sid_pkg::SID_SECOND ##0
    (beep_state_reg == sid_pkg::SID_SECOND && !start)[*2])
    else $error("two-step tone did not switch");
  beep_end_a: assert property (beep_state_reg != sid_pkg::SID_IDLE
    && beep_left_reg == 32'h1 && !start |=> beep_state_reg == sid_pkg::SID_IDLE)
    else $error("beep overran");
  idle_level_a: assert property ($past(beep_state_reg == sid_pkg::SID_IDLE)
    && $stable(idle_act_reg) |-> tone_drive_out == idle_act_reg)
    else $error("buzzer not at idle level");
  lamp_len_a: assert property (lamp_go |=>
    lamp_left_reg == ms_cyc($past(cfg_reg.lamp_ms)) ##1 read_ok_lamp_out == cfg_reg.lamp_inv)
    else $error("lamp time not loaded");
  lamp_pol_a: assert property ($stable(cfg_reg.lamp_inv) && $past(lamp_left_reg) == '0
    |-> read_ok_lamp_out == ~cfg_reg.lamp_inv)
    else $error("lamp idle polarity wrong");
  after_send_a: assert property (cfg_reg.after_send && send_wait_reg && data_sent
    && cfg_reg.ok_en |=> beep_state_reg == sid_pkg::SID_FIRST)
    else $error("beep not given after send");
  timeout_a: assert property (tmo_go && !ok_go && !part_go |=>
    beep_freq_reg == sid_pkg::FREQ_ERROR && beep_left_reg == ms_cyc(sid_pkg::ERROR_MS))
    else $error("timeout beep wrong");
  save_gate_a: assert property (boot_reg == sid_pkg::BOOT_DONE && !save_settings_cmd
    |=> $stable(idle_act_reg) && $stable(power_act_reg))
    else $error("setting applied without save");
endmodule

// ### sid_sounder_model.sv
// Buzzer and lamp stand-in that measures each indication window
`timescale 1ns/100ps
module sid_sounder_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        tone_in,
  input  wire logic        lamp_in,
  input  wire logic        idle_high,
  input  wire logic        lamp_active_high,
  input  wire logic        sample,
  output logic [15:0]      pulses,
  output logic [15:0]      active,
  output logic [15:0]      lamp_cyc,
  output logic             level,
  output logic             res_valid
);
  logic [15:0] p_reg, a_reg, l_reg;
  logic        prev_reg;
  wire         on_now = tone_in != idle_high;
  wire         lit    = lamp_in == lamp_active_high;
  // Counters clear at each sample so a window reports only its own sound and light
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {p_reg, a_reg, l_reg, prev_reg, res_valid} <= '0;
      {pulses, active, lamp_cyc, level} <= '0;
    end else if (sample) begin
      {pulses, active, lamp_cyc, level} <= {p_reg, a_reg, l_reg, tone_in};
      {p_reg, a_reg, l_reg} <= '0;
      prev_reg <= on_now;
      res_valid <= 1'b1;
    end else begin
      res_valid <= 1'b0;
      prev_reg <= on_now;
      p_reg <= p_reg + 16'(on_now && !prev_reg);
      a_reg <= a_reg + 16'(on_now);
      l_reg <= l_reg + 16'(lit);
    end
  end
endmodule

// ### sid_indicator_test.sv
// Self-checking bench for the scan indicator driver
`timescale 1ns/100ps
module sid_indicator_test;
  typedef struct {int p; int pt; int a; int l; logic lv;} sid_exp_type;
  logic        clk, rstn, smp, idle_exp, lamp_hi, sp_beep, si_high, pval;
  logic [32:0] c;
  logic [3:0]  ev, d4;
  logic [15:0] rd, rnd, pulses, active, lamp_cyc;
  logic        tone, lamp, level, rv;
  int          error_cnt, num_checks, f;
  int          blen[5] = '{50, 75, 100, 200, 400};
  int          llen[6] = '{0, 60, 100, 200, 400, 800};
  sid_exp_type q[$];
  sid_exp_type cur;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  sid_indicator #(.MS_CYC(4), .CLK_HZ(20000)) dut (.clk(clk), .rstn(rstn),
    .loudness_max_cmd(c[0]), .loudness_loud_cmd(c[1]), .loudness_normal_cmd(c[2]),
    .loudness_min_cmd(c[3]), .ok_beep_on_cmd(c[4]), .ok_beep_off_cmd(c[5]),
    .beep_len_50_cmd(c[6]), .beep_len_75_cmd(c[7]), .beep_len_100_cmd(c[8]),
    .beep_len_200_cmd(c[9]), .beep_len_400_cmd(c[10]), .tone_medium_cmd(c[11]),
    .tone_step_down_cmd(c[12]), .tone_step_up_cmd(c[13]), .tone_freq_set_cmd(c[14]),
    .tone_freq_digits(rd), .power_beep_off_cmd(c[15]), .power_beep_on_cmd(c[16]),
    .timeout_beep_off_cmd(c[17]), .timeout_beep_on_cmd(c[18]), .partial_beep_cmd(c[19]),
    .partial_beep_val(pval), .beep_idle_low_cmd(c[20]), .beep_idle_high_cmd(c[21]),
    .lamp_off_cmd(c[22]), .lamp_len_60_cmd(c[23]), .lamp_len_100_cmd(c[24]),
    .lamp_len_200_cmd(c[25]), .lamp_len_400_cmd(c[26]), .lamp_len_800_cmd(c[27]),
    .lamp_polarity_normal_cmd(c[28]), .lamp_polarity_invert_cmd(c[29]),
    .save_settings_cmd(c[30]), .indicate_before_send_cmd(c[31]),
    .indicate_after_send_cmd(c[32]), .stored_power_beep(sp_beep),
    .stored_idle_high(si_high), .decode_ok(ev[0]), .decode_partial(ev[1]),
    .read_timeout(ev[2]), .data_sent(ev[3]), .tone_drive_out(tone),
    .read_ok_lamp_out(lamp));
  sid_sounder_model model (.clk(clk), .rstn(rstn), .tone_in(tone), .lamp_in(lamp),
    .idle_high(idle_exp), .lamp_active_high(lamp_hi), .sample(smp), .pulses(pulses),
    .active(active), .lamp_cyc(lamp_cyc), .level(level), .res_valid(rv));
  task automatic chk_cnt(string nm, int e, logic [15:0] s, int tol);
    num_checks++;
    if ($isunknown(s) || int'(s) > e + tol || int'(s) + tol < e) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Extra edge keeps two back-to-back pulses from landing in one time step
  task automatic cmd(int b);
    c[b] <= 1'b1;
    @(posedge clk);
    c <= '0;
    @(posedge clk);
  endtask
  task automatic fset(logic [15:0] d);
    rd <= d;
    cmd(14);
  endtask
  task automatic win(string nm, int evb, int w, int p, int pt, int a, int l);
    if (evb >= 0) ev[evb] <= 1'b1;
    @(posedge clk);
    ev <= '0;
    repeat (w) @(posedge clk);
    q.push_back('{p, pt, a, l, idle_exp});
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
    $display("test %s done", nm);
  endtask
  always @(posedge clk) begin
    if (rv === 1'b1 && q.size() == 0) chk_cnt("result count", 0, 16'h0001, 0);
    else if (rv === 1'b1) begin
      cur = q.pop_front();
      chk_cnt("pulses", cur.p, pulses, cur.pt);
      if (cur.a >= 0) chk_cnt("active", cur.a, active, 10);
      if (cur.l >= 0) chk_cnt("lamp", cur.l, lamp_cyc, 0);
      chk_bit("idle", cur.lv, level);
    end
  end
  initial begin
    {c, ev, rd, smp, rstn, lamp_hi} = '0;
    {idle_exp, sp_beep, si_high, pval} = 4'hf;
    error_cnt = 0;
    num_checks = 0;
    f = $urandom(37420);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    win("startup on", -1, 700, 60, 1, -1, 0);
    sp_beep <= 1'b0;
    // The checker must take the last result before reset clears the model
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    win("startup off", -1, 700, 0, 0, -1, 0);
    cmd(20);
    win("idle pending", -1, 20, 0, 0, -1, 0);
    cmd(30);
    idle_exp <= 1'b0;
    win("idle saved", -1, 20, 0, 1, -1, 0);
    win("idle low beep", 0, 1700, 30, 1, -1, 800);
    cmd(21);
    cmd(30);
    idle_exp <= 1'b1;
    win("idle high", -1, 20, 0, 1, -1, 0);
    win("partial", 1, 300, 10, 1, -1, 0);
    pval <= 1'b0;
    cmd(19);
    win("partial off", 1, 300, 0, 0, -1, 0);
    pval <= 1'b1;
    cmd(19);
    cmd(5);
    win("partial muted", 1, 300, 0, 0, -1, 0);
    win("ok beep off", 0, 1700, 0, 0, -1, 800);
    cmd(4);
    win("timeout off", 2, 900, 0, 0, -1, 0);
    cmd(18);
    win("timeout on", 2, 900, 40, 1, -1, 0);
    fset(16'h4000);
    fset(16'h0a00);
    fset(16'h0000);
    win("freq refused", 0, 1700, 40, 1, -1, 800);
    f = 0;
    for (int i = 3; i >= 0; i--) begin
      d4 = (i == 3) ? 4'($urandom_range(9, 1)) : 4'($urandom_range(9, 0));
      rnd[i*4 +: 4] = d4;
      f = f * 10 + int'(d4);
    end
    fset(rnd);
    win("random freq", 0, 1700, (200 * f + 19999) / 20000, 1, -1, 800);
    fset(16'h3000);
    for (int i = 0; i < 5; i++) begin
      cmd(6 + i);
      win("beep length", 0, 1700, blen[i] * 12 / 20, 1, -1, 800);
    end
    cmd(6);
    for (int i = 0; i < 6; i++) begin
      cmd(22 + i);
      win("lamp length", 0, 1700 + llen[i] * 2, 30, 1, -1, llen[i] * 4);
    end
    cmd(25);
    cmd(29);
    lamp_hi <= 1'b1;
    win("polarity", -1, 5, 0, 0, -1, 0);
    win("lamp invert", 0, 1700, 30, 1, -1, 800);
    cmd(28);
    lamp_hi <= 1'b0;
    win("polarity", -1, 5, 0, 0, -1, 0);
    fset(16'h0100);
    cmd(10);
    for (int i = 0; i < 4; i++) begin
      cmd(i);
      win("loudness", 0, 1700, 8, 1, 1600 >> (i + 1), 800);
    end
    cmd(0);
    fset(16'h3000);
    cmd(9);
    cmd(12);
    win("step down", 0, 1700, 120, 2, -1, 800);
    cmd(13);
    win("step up", 0, 1700, 120, 2, -1, 800);
    cmd(11);
    cmd(6);
    cmd(32);
    win("wait send", 0, 300, 0, 0, -1, 0);
    win("after send", 3, 1700, 30, 1, -1, 800);
    cmd(31);
    repeat (3) @(posedge clk);
    if (q.size() != 0) chk_cnt("pending results", 0, 16'(q.size()), 0);
    tally_and_finish();
  end
endmodule
